// *** hdl/cmp_ref_pkg.sv ***
// Package: register map, field positions and types of the comparator control block
package cmp_ref_pkg;
   // Word byte addresses on the register bus
   localparam logic [3:0] ADDR_REF_SELECT = 4'h0;
   localparam logic [3:0] ADDR_CONTROL    = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK   = 4'hc;
   // Reference select fields
   localparam int REF_EXT_BIT  = 7;
   localparam int REF_BGR_BIT  = 6;
   localparam int REF_LVL_HI   = 5;
   localparam int REF_LVL_LO   = 2;
   // Control fields
   localparam int CTL_HYST_BIT = 7;
   localparam int CTL_INV_BIT  = 5;
   localparam int CTL_IF_BIT   = 4;
   localparam int CTL_IE_BIT   = 3;
   localparam int CTL_STAT_BIT = 2;
   localparam int CTL_RES_BIT  = 1;
   localparam int CTL_PON_BIT  = 0;
   // Writable masks; reserved bits stay zero
   localparam logic [7:0] REF_WR_MASK = 8'hfc;
   localparam logic [7:0] CTL_WR_MASK = 8'ha9;
   // Reset values
   localparam logic [7:0] REF_RESET   = 8'h00;
   localparam logic [7:0] CTL_RESET   = 8'h80;
   // Interrupt status bits
   localparam int IRQ_EDGE_BIT = 0;
   localparam int IRQ_W        = 1;
   // Fixed bandgap level in millivolts, and level step
   localparam int BANDGAP_MV   = 1200;
   localparam int LEVEL_STEP_MV = 200;

   // Source of the negative comparator input
   typedef enum logic [1:0] {
      SRC_LEVEL,
      SRC_BANDGAP,
      SRC_EXTERNAL
   } ref_source_t;

   // Analog-facing control bundle
   typedef struct packed {
      ref_source_t source;
      logic [3:0]  level_code;
      logic        hysteresis_enable;
      logic        power_on;
   } analog_ctrl_t;

   // Wishbone request bundle
   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
endpackage

// *** hdl/comparator_reference_control.sv ***
// Comparator reference and control block with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Ext-select bit routes external pin to input
// R2: Bandgap-select bit connects 1.2V bandgap
// R3: Level field bits 5:2 picks sixteen levels
// R4: External beats bandgap beats level field
// R5: Level code n gives (n+1) times 0.2V
// R6: Software writes zero to reserved bits
// R7: Control resets to 80h, hysteresis enabled
// R8: Software should keep hysteresis enabled
// R9: Inversion bit resets clear, inverts output
// R10: Edge select: rising normal, falling inverted
// R11: Reference register resets to all zeros
// R12: Edge sets sticky flag and status bit; enable gates flag, irq_mask gates status
// R13: Status bit shows synchronised inverted result
module comparator_reference_control (
   input  wire logic                       sys_clk,
   input  wire logic                       rstn,
   input  wire cmp_ref_pkg::wb_req_t       wb_req,
   output logic        [31:0]              wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       comparator_raw,
   output cmp_ref_pkg::analog_ctrl_t       analog_ctrl,
   output logic        [15:0]              level_mv,
   output logic                            comparator_out,
   output logic                            irq
);
   import cmp_ref_pkg::*;

   // Whole block state
   typedef struct packed {
      logic [7:0]   ref_select;
      logic [7:0]   control;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic         sync1;
      logic         sync2;
      logic         prev_raw;
      logic [31:0]  rdata;
      logic         ack;
      analog_ctrl_t actrl;
      logic [15:0]  mv;
      logic         comparator_result_bit;
      logic         irq;
   } state_t;

   state_t st;
   state_t next_st;

   // Byte-lane merge of a write into an 8-bit register
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] wmask,
                                         input wb_req_t r);
      merge8 = r.sel[0] ? ((old & ~wmask) | (r.dat[7:0] & wmask)) : old;
   endfunction

   // Source priority decode
   function automatic ref_source_t pick_source(input logic [7:0] rs);
      if (rs[REF_EXT_BIT]) begin                       // [R1] [R4]
         pick_source = SRC_EXTERNAL;
      end else if (rs[REF_BGR_BIT]) begin              // [R2] [R4]
         pick_source = SRC_BANDGAP;
      end else begin
         pick_source = SRC_LEVEL;                       // [R3]
      end
   endfunction

   logic access;
   logic wr;
   logic edge_seen;
   logic [7:0] ctl_rd;
   logic [3:0] lvl;

   always_comb begin
      next_st = st;
      access = wb_req.cyc && wb_req.stb && !st.ack;
      wr = access && wb_req.we;
      // Two-flop synchroniser for the analog result
      next_st.sync1 = comparator_raw;
      next_st.sync2 = st.sync1;
      next_st.prev_raw = st.sync2;
      // Rising edge normally, falling edge when inverted
      edge_seen = st.control[CTL_INV_BIT] ? (st.prev_raw && !st.sync2)
                                          : (!st.prev_raw && st.sync2);   // [R10]
      next_st.comparator_result_bit = st.sync2 ^ st.control[CTL_INV_BIT];                 // [R9] [R13]
      // Register writes; reserved bits masked to zero
      next_st.ack = access;
      if (wr && wb_req.adr == ADDR_REF_SELECT) begin
         next_st.ref_select = merge8(st.ref_select, REF_WR_MASK, wb_req);  // [R6]
      end
      if (wr && wb_req.adr == ADDR_CONTROL) begin
         next_st.control = merge8(st.control, CTL_WR_MASK, wb_req);        // [R6] [R8]
         // Flag clears by writing one; a coincident edge wins
         if (wb_req.sel[0] && wb_req.dat[CTL_IF_BIT]) begin
            next_st.control[CTL_IF_BIT] = 1'b0;
         end
      end
      if (wr && wb_req.adr == ADDR_IRQ_STATUS && wb_req.sel[0]) begin
         next_st.irq_status = st.irq_status & ~wb_req.dat[IRQ_W-1:0];
      end
      if (wr && wb_req.adr == ADDR_IRQ_MASK && wb_req.sel[0]) begin
         next_st.irq_mask = wb_req.dat[IRQ_W-1:0];
      end
      if (edge_seen) begin
         next_st.control[CTL_IF_BIT] = 1'b1;                              // [R12]
         next_st.irq_status[IRQ_EDGE_BIT] = 1'b1;
      end
      // Status bit mirrors the presented output
      next_st.control[CTL_STAT_BIT] = 1'b0;
      next_st.control[CTL_RES_BIT] = 1'b0;
      // Read data
      ctl_rd = st.control;
      ctl_rd[CTL_STAT_BIT] = st.comparator_result_bit;                                     // [R13]
      next_st.rdata = 32'h0;
      if (access && !wb_req.we) begin
         unique case (wb_req.adr)
            ADDR_REF_SELECT: next_st.rdata = {24'h0, st.ref_select};
            ADDR_CONTROL:    next_st.rdata = {24'h0, ctl_rd};
            ADDR_IRQ_STATUS: next_st.rdata = {31'h0, st.irq_status};
            ADDR_IRQ_MASK:   next_st.rdata = {31'h0, st.irq_mask};
            default:         next_st.rdata = 32'h0;
         endcase
      end
      // Analog controls from the registered settings
      lvl = st.ref_select[REF_LVL_HI:REF_LVL_LO];                          // [R3]
      next_st.actrl.source = pick_source(st.ref_select);
      next_st.actrl.level_code = lvl;
      next_st.actrl.hysteresis_enable = st.control[CTL_HYST_BIT];          // [R7]
      next_st.actrl.power_on = st.control[CTL_PON_BIT];
      unique case (pick_source(st.ref_select))
         SRC_BANDGAP: next_st.mv = 16'(BANDGAP_MV);                        // [R2]
         SRC_LEVEL:   next_st.mv = 16'((32'(lvl) + 1) * LEVEL_STEP_MV);     // [R5]
         default:     next_st.mv = 16'h0;
      endcase
      // Interrupt: control enable or status mask
      next_st.irq = (st.control[CTL_IF_BIT] && st.control[CTL_IE_BIT])
                    || |(st.irq_status & st.irq_mask);                     // [R12]
   end

   // State register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.ref_select <= REF_RESET;                                       // [R11]
         st.control <= CTL_RESET;                                          // [R7] [R9]
         st.actrl.hysteresis_enable <= 1'b1;
         st.mv <= 16'(LEVEL_STEP_MV);
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.rdata;
   assign wb_ack_o = st.ack;
   assign analog_ctrl = st.actrl;
   assign level_mv = st.mv;
   assign comparator_out = st.comparator_result_bit;
   assign irq = st.irq;

   // Checks
   ext_priority_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      st.ref_select[REF_EXT_BIT] |=> analog_ctrl.source == SRC_EXTERNAL)   // [R1]
      else $error("external select not routed");
   bgr_priority_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st.ref_select[7:6] == 2'b01) |=> analog_ctrl.source == SRC_BANDGAP
         && level_mv == 16'(BANDGAP_MV))                                   // [R2]
      else $error("bandgap select wrong");
   level_pick_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st.ref_select[7:6] == 2'b00) |=> analog_ctrl.source == SRC_LEVEL
         && analog_ctrl.level_code == $past(st.ref_select[5:2]))          // [R3]
      else $error("level code not selected");
   source_order_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      analog_ctrl.source == SRC_LEVEL |-> $past(st.ref_select[7:6]) == 2'b00) // [R4]
      else $error("source priority broken");
   level_volts_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      analog_ctrl.source == SRC_LEVEL |->
         level_mv == 16'((32'(analog_ctrl.level_code) + 1) * LEVEL_STEP_MV)) // [R5]
      else $error("level voltage mismatch");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      st.ref_select[1:0] == 2'b00 && st.control[6] == 1'b0)              // [R6]
      else $error("reserved bits set");
   hyst_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      ##1 analog_ctrl.hysteresis_enable == $past(st.control[7]))          // [R7]
      else $error("hysteresis output wrong");
   invert_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      ##1 comparator_out == ($past(st.sync2) ^ $past(st.control[5])))    // [R9]
      else $error("output inversion wrong");
   edge_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!st.control[5] && $rose(st.sync2)) |=> st.control[4])             // [R10]
      else $error("rising edge missed");
   fall_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st.control[5] && $fell(st.sync2)) |=> st.control[4])              // [R10]
      else $error("falling edge missed");
   irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st.control[4] && st.control[3]) |=> irq)                          // [R12]
      else $error("interrupt not raised");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench for the comparator reference control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cmp_ref_pkg::*;
   logic                sys_clk;
   logic                rstn;
   wb_req_t             wb_req;
   logic         [31:0] wb_dat_o;
   logic                wb_ack_o;
   logic                comparator_raw;
   analog_ctrl_t        analog_ctrl;
   logic         [15:0] level_mv;
   logic                comparator_out;
   logic                irq;
   int                  n_mismatch;
   int                  comparisons;
   int                  cycles;
   logic         [31:0] rd;

   comparator_reference_control dut_u (
      .sys_clk        (sys_clk),
      .rstn           (rstn),
      .wb_req         (wb_req),
      .wb_dat_o       (wb_dat_o),
      .wb_ack_o       (wb_ack_o),
      .comparator_raw (comparator_raw),
      .analog_ctrl    (analog_ctrl),
      .level_mv       (level_mv),
      .comparator_out (comparator_out),
      .irq            (irq)
   );

   // Clock at 40 MHz
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Counts, verdict and end of run
   task automatic tally_and_finish();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      check_word({31'h0, got}, {31'h0, exp}, what);
   endtask

   // Classic single Wishbone cycle; waits for ack with no timeout of its own, only the hang guard bounds the wait
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [7:0] wdat);
      @(posedge sys_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wdat}};
      do begin
         @(posedge sys_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_req <= '0;
   endtask

   task automatic t_reset();
      wb_xfer(1'b0, ADDR_REF_SELECT, 8'h00);
      check_word(rd, 32'h00, "ref select reset");
      wb_xfer(1'b0, ADDR_CONTROL, 8'h00);
      check_word(rd, 32'h80, "control reset");
      check_bit(analog_ctrl.hysteresis_enable, 1'b1, "hysteresis on");
      check_word({16'h0, level_mv}, 32'd200, "lowest level");
      $display("test reset done");
   endtask

   task automatic t_ref();
      for (int i = 0; i < 16; i++) begin
         wb_xfer(1'b1, ADDR_REF_SELECT, {2'b00, i[3:0], 2'b00});
         repeat (2) @(posedge sys_clk);
         check_word({16'h0, level_mv}, (i + 1) * 200, "level mv");
         check_word({30'h0, analog_ctrl.source}, {30'h0, SRC_LEVEL}, "level src");
      end
      wb_xfer(1'b1, ADDR_REF_SELECT, 8'hff);
      repeat (2) @(posedge sys_clk);
      check_word({30'h0, analog_ctrl.source}, {30'h0, SRC_EXTERNAL}, "ext src");
      wb_xfer(1'b0, ADDR_REF_SELECT, 8'h00);
      check_word(rd, 32'hfc, "reserved bits");
      wb_xfer(1'b1, ADDR_REF_SELECT, 8'h7c);
      repeat (2) @(posedge sys_clk);
      check_word({30'h0, analog_ctrl.source}, {30'h0, SRC_BANDGAP}, "bandgap src");
      check_word({16'h0, level_mv}, 32'd1200, "bandgap mv");
      wb_xfer(1'b0, 4'h2, 8'h00);
      check_word(rd, 32'h0, "unmapped read");
      $display("test reference done");
   endtask

   task automatic t_edge();
      wb_xfer(1'b1, ADDR_CONTROL, 8'h88);
      comparator_raw <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check_bit(comparator_out, 1'b1, "out plain");
      check_bit(irq, 1'b1, "irq rising");
      wb_xfer(1'b0, ADDR_CONTROL, 8'h00);
      check_word(rd, 32'h9c, "flag set");
      wb_xfer(1'b1, ADDR_CONTROL, 8'hb8);
      repeat (6) @(posedge sys_clk);
      check_bit(irq, 1'b0, "flag cleared");
      check_bit(comparator_out, 1'b0, "out inverted");
      comparator_raw <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check_bit(irq, 1'b1, "irq falling");
      wb_xfer(1'b0, ADDR_CONTROL, 8'h00);
      check_word(rd, 32'hbc, "inverted status");
      wb_xfer(1'b1, ADDR_CONTROL, 8'hb8);
      comparator_raw <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check_bit(irq, 1'b0, "no rising when inverted");
      $display("test edge done");
   endtask

   task automatic t_mask();
      wb_xfer(1'b1, ADDR_CONTROL, 8'h80);
      wb_xfer(1'b1, ADDR_IRQ_STATUS, 8'h01);
      wb_xfer(1'b1, ADDR_IRQ_MASK, 8'h01);
      repeat (3) @(posedge sys_clk);
      check_bit(irq, 1'b0, "status clear before edge");
      comparator_raw <= 1'b0;
      repeat (6) @(posedge sys_clk);
      comparator_raw <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check_bit(irq, 1'b1, "masked path irq");
      wb_xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
      check_word(rd, 32'h1, "status sticky");
      wb_xfer(1'b1, ADDR_IRQ_STATUS, 8'h01);
      repeat (3) @(posedge sys_clk);
      check_bit(irq, 1'b0, "status cleared");
      $display("test mask done");
   endtask

   initial begin
      rstn = 1'b0;
      wb_req = '0;
      comparator_raw = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      cycles = 0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_ref();
      t_edge();
      t_mask();
      tally_and_finish();
   end
endmodule
`default_nettype wire
